// ===== testbench/dsf_host_model.sv
// Host serial master model for the special-function decoder bench.
// Assumes the bench calls send only between frames.
`timescale 1ns/1ns
`default_nettype none
module dsf_host_model (
	output logic      linkClk,         // Runs only inside frames.
	output logic      frameSelN,       // Frame select, active low.
	output logic      serialDataIn,    // Data to the decoder.
	input  wire logic serial_data_out  // Readback from the decoder.
);
	logic [23:0] rdWord; // Word shifted in during the last frame.
	initial begin
		linkClk = 1'b0;
		frameSelN = 1'b1;
		serialDataIn = 1'b0;
		rdWord = 24'h000000;
	end
	// ----------------------------------------------------------------
	// Frame task
	// ----------------------------------------------------------------
	// Sends n bits MSB first; readback is taken on each falling edge.
	// The data line is inverted after the frame so stale data never looks valid.
	task automatic send(input logic [23:0] w, input int n);
		frameSelN = 1'b0;
		for (int i = 0; i < n; i++) begin
			serialDataIn = (i < 24) ? w[23-i] : 1'b0;
			#6 linkClk = 1'b1;
			#6 linkClk = 1'b0;
			rdWord = {rdWord[22:0], serial_data_out};
		end
		#6 frameSelN = 1'b1;
		serialDataIn = ~serialDataIn;
		#500; // Gap well above the 250 ns minimum; lets the word execute.
	endtask
endmodule // dsf_host_model
`default_nettype wire

// ===== testbench/tb_dac_special_function_decoder.sv
// Self-checking bench for the special-function decoder.
// Assumes dsf_pkg and dsf_decoder compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_dac_special_function_decoder import dsf_pkg::*; ;
	logic ref_clk, rstn, checksumErrEvent, overTempIn, gpioIn; // Bench-driven inputs.
	wire  linkClk, frameSelN, serialDataIn;                    // Driven by the host model.
	logic serial_data_out, serialDataOutOe, checksum_error_out_n, monitorEnable;
	logic inputBankSecondary, thermalShutdownEn, softPowerDown, monitorPinSel;
	logic monitorPinSecond, gpioOut, gpioOe;
	logic [13:0] groupOffsetZero, groupOffsetOne;
	logic [15:0] channelUsesSecondary;
	logic [3:0]  monitorChannel;
	int          fail_count, n_checks, cycles;
	dsf_decoder DUT (.ref_clk, .rstn, .linkClk, .frameSelN, .serialDataIn, .serial_data_out,
		.serialDataOutOe, .checksumErrEvent, .overTempIn, .checksum_error_out_n,
		.inputBankSecondary, .thermalShutdownEn, .softPowerDown, .groupOffsetZero,
		.groupOffsetOne, .channelUsesSecondary, .monitorEnable, .monitorPinSel,
		.monitorChannel, .monitorPinSecond, .gpioIn, .gpioOut, .gpioOe);
	dsf_host_model host (.linkClk, .frameSelN, .serialDataIn, .serial_data_out);
	// ----------------------------------------------------------------
	// Clock, timeout and shared tasks
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// A hang is cut short well after the expected run of about 600 cycles.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic drv(); // Inputs change 1 ns after the rising edge.
		@(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [5:0] fn, input logic [15:0] arg);
		host.send({MODE_SPECIAL, fn, arg}, 24);
	endtask
	// Selects a readback, then clocks it out with a no-operation frame.
	task automatic rd(input logic [5:0] sel, input logic [23:0] exp);
		wr(FN_READSEL, {RB_TYPE_SPECIAL, sel, 7'h00});
		chk(24'(serialDataOutOe), 24'h1);
		wr(FN_NOP, 16'h0000);
		chk(host.rdWord, exp);
		chk(24'(serialDataOutOe), 24'h0);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_ctrl();
		wr(FN_CTRL, 16'hFFE7);
		chk(24'({inputBankSecondary, thermalShutdownEn, softPowerDown}), 24'h7);
		wr(FN_CTRL, 16'h0005);
		chk(24'({inputBankSecondary, thermalShutdownEn, softPowerDown}), 24'h5);
		$display("ctrl test done");
	endtask
	task automatic t_ofs();
		wr(FN_GROUP_OFFSET_ZERO, 16'hFFFF);
		wr(FN_GROUP_OFFSET_ONE, 16'h1234);
		chk(24'(groupOffsetZero), 24'h003FFF);
		chk(24'(groupOffsetOne), 24'h001234);
		rd(RB_GROUP_OFFSET_ZERO, 24'h003FFF);
		rd(RB_GROUP_OFFSET_ONE, 24'h001234);
		$display("offset test done");
	endtask
	task automatic t_bank();
		wr(FN_BANK0, 16'hAB5A);
		wr(FN_BANK1, 16'h12C3);
		chk(24'(channelUsesSecondary), 24'h00C35A);
		rd(RB_BANK1, 24'h0000C3);
		rd(RB_BANK0, 24'h00005A);
		wr(FN_BANKALL, 16'h00FF);
		chk(24'(channelUsesSecondary), 24'h00FFFF);
		wr(FN_BANKALL, 16'hFF00);
		chk(24'(channelUsesSecondary), 24'h000000);
		$display("bank test done");
	endtask
	task automatic t_mon();
		wr(FN_MONITOR, 16'hFFE5);
		chk(24'({monitorEnable, monitorPinSel, monitorChannel}), 24'h25);
		wr(FN_MONITOR, 16'h003D);
		chk(24'({monitorEnable, monitorPinSel, monitorPinSecond}), 24'h7);
		wr(FN_MONITOR, 16'h0010);
		chk(24'({monitorEnable, monitorPinSel}), 24'h0);
		$display("monitor test done");
	endtask
	task automatic t_gpio();
		wr(FN_GPIO, 16'hFFFF);
		chk(24'({gpioOe, gpioOut}), 24'h3);
		rd(RB_GPIO, 24'h000001);
		wr(FN_GPIO, 16'h0000);
		chk(24'(gpioOe), 24'h0);
		drv();
		gpioIn = 1'b1;
		rd(RB_GPIO, 24'h000001);
		drv();
		gpioIn = 1'b0;
		rd(RB_GPIO, 24'h000000);
		$display("gpio test done");
	endtask
	task automatic t_err();
		drv();
		overTempIn = 1'b1;
		checksumErrEvent = 1'b1;
		drv();
		checksumErrEvent = 1'b0;
		repeat (4) drv();
		chk(24'(checksum_error_out_n), 24'h0);
		rd(RB_CTRL, 24'h00001D);
		chk(24'(checksum_error_out_n), 24'h1);
		rd(RB_CTRL, 24'h000015);
		$display("error test done");
	endtask
	task automatic t_refuse();
		wr(6'h04, 16'hFFFF);
		host.send({2'b01, FN_GROUP_OFFSET_ZERO, 16'h0000}, 24);
		host.send({MODE_SPECIAL, FN_GROUP_OFFSET_ZERO, 16'h0000}, 23);
		host.send({MODE_SPECIAL, FN_GROUP_OFFSET_ZERO, 16'h0000}, 25);
		chk(24'(groupOffsetZero), 24'h003FFF);
		chk(24'({inputBankSecondary, thermalShutdownEn, softPowerDown}), 24'h5);
		wr(FN_READSEL, {RB_TYPE_SPECIAL, 6'h04, 7'h00});
		chk(24'(serialDataOutOe), 24'h0);
		$display("refuse test done");
	endtask
	initial begin
		rstn = 1'b1; // Falls at 1 ns so the link-side reset sees a clean edge.
		checksumErrEvent = 1'b0;
		overTempIn = 1'b0;
		gpioIn = 1'b0;
		#1 rstn = 1'b0;
		repeat (5) drv();
		rstn = 1'b1;
		drv();
		chk(24'({checksum_error_out_n, serialDataOutOe, channelUsesSecondary}), 24'h20000);
		t_ctrl();
		t_ofs();
		t_bank();
		t_mon();
		t_gpio();
		t_err();
		t_refuse();
		summarize();
	end
endmodule // tb_dac_special_function_decoder
`default_nettype wire

// ===== verilog/dsf_decoder.sv
// Special-function word decoder of a 16-channel serial-input converter.
// Assumes a host SPI master: data sampled on link clock rising edges,
// frameSelN low for a frame; the control logic runs on ref_clk.
// Operation
// - Mode 00 words decode as special functions.
// - Code 000001 stores argument bits 2..0.
// - Bit 4 reads over-temperature flag.
// - Bit 3 reads pending checksum error.
// - Bit 2 picks secondary input bank.
// - Bit 1 enables thermal shutdown.
// - Bit 0 requests software power-down.
// - Codes 000010/000011 load 14-bit group offsets.
// - Codes 000110/000111 load bank select bytes.
// - Code 001011 loads both bank selects.
// - Bank bit one routes channel to secondary.
// - Code 001100 argument bit 5 enables monitor.
// - Bit 4 clear monitors channel in 3..0.
// - Bits 5,4 set pick monitor pin.
// - Code 001101 sets pin direction and value.
// - All-zero word is no operation.
// - Code 000101 selects register for readback.
// - Type 100 reads special registers, pin.
// - Readback drives data out next frame.
// - Control readback clears error, releases pin.
`timescale 1ns/1ns
`default_nettype none
module dsf_decoder
	import dsf_pkg::*;
(
	input  wire logic               ref_clk,            // Control clock, 20 MHz.
	input  wire logic               rstn,               // Reset, active low; synchronous in the ref domain, asynchronous in the link domain.
	input  wire logic               linkClk,            // Serial clock from the host.
	input  wire logic               frameSelN,          // Frame select, active low.
	input  wire logic               serialDataIn,       // Serial data from the host.
	output logic                    serial_data_out,    // Serial readback data.
	output logic                    serialDataOutOe,    // High while readback drives.
	input  wire logic               checksumErrEvent,   // One-cycle pulse on a bad packet.
	input  wire logic               overTempIn,         // Die temperature above limit.
	output logic                    checksum_error_out_n, // Error pin, active low.
	output logic                    inputBankSecondary, // Channel writes go to secondary.
	output logic                    thermalShutdownEn,  // Thermal shutdown enabled.
	output logic                    softPowerDown,      // Outputs powered down.
	output logic [OFS_W-1:0]        groupOffsetZero,    // First group offset.
	output logic [OFS_W-1:0]        groupOffsetOne,     // Second group offset.
	output logic [2*BANK_W-1:0]     channelUsesSecondary, // Per-channel output bank.
	output logic                    monitorEnable,      // Monitor multiplexer on.
	output logic                    monitorPinSel,      // Monitor routes an input pin.
	output logic [3:0]              monitorChannel,     // Channel being monitored.
	output logic                    monitorPinSecond,   // Second monitor pin chosen.
	input  wire logic               gpioIn,             // General-purpose pin level.
	output logic                    gpioOut,            // General-purpose pin drive value.
	output logic                    gpioOe              // High while the pin is driven.
);
	// ----------------------------------------------------------------
	// Link domain: frame reception and readback shifting
	// ----------------------------------------------------------------
	logic [CNT_W-1:0]  bitCnt_r;      // Bits seen in this frame.
	logic [WORD_W-1:0] shift_r;       // Incoming shift register.
	dsf_word_t         holdWord_r;    // Last complete word, stable between frames.
	logic              wordTgl_r;     // Toggles once per complete 24-bit word.
	logic              readDoneTgl_r; // Toggles when readback data has gone out.
	logic              sdoBit_r;      // Current readback bit.
	logic [WORD_W-1:0] readWord_r;    // Readback word, ref domain.
	dsf_rb_state_t     rbState_r;     // Readback state, ref domain.
	logic              overrun_r;     // Frame ran past 24 bits; vetoes the word.

	// Frame select high clears the counter and the data bit at once, so a
	// stopped link clock between frames leaves nothing half-done.
	always_ff @(posedge linkClk or posedge frameSelN) begin
		if (frameSelN) begin
			bitCnt_r <= '0;
			sdoBit_r <= 1'b0;
		end else begin
			if (bitCnt_r != OVER_BIT) begin
				bitCnt_r <= bitCnt_r + 5'h01;
			end
			// The readback word is held still by the ref domain for the
			// whole frame, so reading it here is safe.
			if (bitCnt_r <= LAST_BIT) begin
				sdoBit_r <= readWord_r[LAST_BIT - bitCnt_r];
			end else begin
				sdoBit_r <= 1'b0;
			end
		end
	end

	// Incoming bits shift in MSB first.
	always_ff @(posedge linkClk) begin
		shift_r <= {shift_r[WORD_W-2:0], serialDataIn};
	end

	// The word is captured at the 24th bit; an overlong frame is vetoed by
	// the overrun mark, so the ref domain never executes it.
	always_ff @(posedge linkClk) begin
		if (!frameSelN && bitCnt_r == LAST_BIT) begin
			holdWord_r <= {shift_r[WORD_W-2:0], serialDataIn};
		end
	end

	// The overrun mark is cleared only by the first bit of the next frame, so
	// it still stands when the ref domain sees the frame end and can veto it.
	always_ff @(posedge linkClk or negedge rstn) begin
		if (!rstn) begin
			wordTgl_r     <= 1'b0;
			readDoneTgl_r <= 1'b0;
			overrun_r     <= 1'b0;
		end else if (!frameSelN) begin
			if (bitCnt_r == LAST_BIT) begin
				wordTgl_r <= ~wordTgl_r;
			end
			if (bitCnt_r == LAST_BIT && rbState_r == RB_ARMED) begin
				readDoneTgl_r <= ~readDoneTgl_r;
			end
			if (bitCnt_r == '0) begin
				overrun_r <= 1'b0;
			end else if (bitCnt_r == OVER_BIT) begin
				overrun_r <= 1'b1;
			end
		end
	end

	assign serial_data_out = sdoBit_r;

	// ----------------------------------------------------------------
	// Crossings into the ref domain
	// ----------------------------------------------------------------
	logic [2:0] syncS_r;   // Frame select synchroniser and edge stage.
	logic [1:0] wordS_r;   // Word toggle synchroniser.
	logic [1:0] doneS_r;   // Readback-done toggle synchroniser.
	logic [1:0] overS_r;   // Overrun flag synchroniser.
	logic [1:0] tempS_r;   // Over-temperature synchroniser.
	logic [1:0] gpioS_r;   // Pin level synchroniser.
	logic       wordSeen_r; // Word toggle already acted upon.
	logic       doneSeen_r; // Done toggle already acted upon.
	logic       execNow;    // Execute the held word this cycle.
	logic       readDone;   // Readback has been clocked out.

	// Each first stage feeds only its second stage.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			syncS_r <= 3'h7;
			wordS_r <= 2'h0;
			doneS_r <= 2'h0;
			overS_r <= 2'h0;
			tempS_r <= 2'h0;
			gpioS_r <= 2'h0;
			wordSeen_r <= 1'b0;
			doneSeen_r <= 1'b0;
		end else begin
			syncS_r <= {syncS_r[1:0], frameSelN};
			wordS_r <= {wordS_r[0], wordTgl_r};
			doneS_r <= {doneS_r[0], readDoneTgl_r};
			overS_r <= {overS_r[0], overrun_r};
			tempS_r <= {tempS_r[0], overTempIn};
			gpioS_r <= {gpioS_r[0], gpioIn};
			if (syncS_r[1] && !syncS_r[2]) begin
				wordSeen_r <= wordS_r[1];
			end
			doneSeen_r <= doneS_r[1];
		end
	end

	// A word runs only when the frame ends and exactly 24 bits arrived.
	assign execNow  = syncS_r[1] && !syncS_r[2] && (wordS_r[1] != wordSeen_r) && !overS_r[1];
	assign readDone = doneS_r[1] != doneSeen_r;

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	logic       isSpecial;  // Word carries a special function.
	logic [2:0] rbType;     // Readback register type.
	logic [5:0] rbSel;      // Readback selection.
	logic       rbValid;    // Readback selection is defined.

	assign isSpecial = execNow && holdWord_r.mode == MODE_SPECIAL;
	assign rbType    = holdWord_r.arg[RB_TYPE_HI:RB_TYPE_LO];
	assign rbSel     = holdWord_r.arg[RB_SEL_HI:RB_SEL_LO];

	// Reserved selections are rejected here and arm nothing.
	always_comb begin
		if (rbType <= RB_TYPE_LIMIT) begin
			rbValid = rbSel >= RB_CH_FIRST && rbSel <= RB_CH_LAST;
		end else if (rbType == RB_TYPE_SPECIAL) begin
			rbValid = rbSel == RB_CTRL || rbSel == RB_GROUP_OFFSET_ZERO || rbSel == RB_GROUP_OFFSET_ONE ||
				rbSel == RB_BANK0 || rbSel == RB_BANK1 || rbSel == RB_GPIO;
		end else begin
			rbValid = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [CTRL_W-1:0] ctrl_r;     // Bank, shutdown enable, power-down.
	logic              errFlag_r;  // Checksum error pending.
	logic              errOutN_r;  // Error pin, active low.
	logic [BANK_W-1:0] bankLo_r;   // Channels 7..0.
	logic [BANK_W-1:0] bankHi_r;   // Channels 15..8.
	logic [MON_W-1:0]  mon_r;      // Monitor setting.
	logic [1:0]        gpioCfg_r;  // Direction and drive value.
	logic [OFS_W-1:0]  group_offset_zero_r;     // First group offset.
	logic [OFS_W-1:0]  group_offset_one_r;     // Second group offset.
	logic              ctrlRead_r; // Armed readback targets the control bits.

	// Only three control bits are stored; the flag positions the host
	// sends are dropped, so a careless host cannot fake them.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ctrl_r <= '0;
		end else if (isSpecial && holdWord_r.func == FN_CTRL) begin
			ctrl_r <= holdWord_r.arg[CTRL_W-1:0];
		end
	end

	assign inputBankSecondary = ctrl_r[2];
	assign thermalShutdownEn  = ctrl_r[1];
	assign softPowerDown      = ctrl_r[0];

	// Group offsets take argument bits 13..0.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			group_offset_zero_r <= '0;
			group_offset_one_r <= '0;
		end else if (isSpecial) begin
			if (holdWord_r.func == FN_GROUP_OFFSET_ZERO) begin
				group_offset_zero_r <= holdWord_r.arg[OFS_W-1:0];
			end
			if (holdWord_r.func == FN_GROUP_OFFSET_ONE) begin
				group_offset_one_r <= holdWord_r.arg[OFS_W-1:0];
			end
		end
	end

	assign groupOffsetZero = group_offset_zero_r;
	assign groupOffsetOne  = group_offset_one_r;

	// Bank select bytes; the block code writes both at once.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			bankLo_r <= '0;
			bankHi_r <= '0;
		end else if (isSpecial) begin
			if (holdWord_r.func == FN_BANK0 || holdWord_r.func == FN_BANKALL) begin
				bankLo_r <= holdWord_r.arg[BANK_W-1:0];
			end
			if (holdWord_r.func == FN_BANK1 || holdWord_r.func == FN_BANKALL) begin
				bankHi_r <= holdWord_r.arg[BANK_W-1:0];
			end
		end
	end

	assign channelUsesSecondary = {bankHi_r, bankLo_r};

	// Monitor setting; the pin bit is stored gated by the enable bit.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			mon_r <= '0;
		end else if (isSpecial && holdWord_r.func == FN_MONITOR) begin
			mon_r <= {holdWord_r.arg[MON_EN_BIT], holdWord_r.arg[MON_EN_BIT] & holdWord_r.arg[MON_PIN_BIT],
				holdWord_r.arg[MON_PIN_BIT-1:0]};
		end
	end
	assign monitorEnable    = mon_r[MON_EN_BIT];
	assign monitorPinSel    = mon_r[MON_PIN_BIT];
	assign monitorChannel   = mon_r[3:0];
	assign monitorPinSecond = mon_r[0];

	// General-purpose pin starts as an input.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			gpioCfg_r <= '0;
		end else if (isSpecial && holdWord_r.func == FN_GPIO) begin
			gpioCfg_r <= holdWord_r.arg[1:0];
		end
	end

	assign gpioOut = gpioCfg_r[GPIO_VAL_BIT];
	assign gpioOe  = gpioCfg_r[GPIO_DIR_BIT];

	// Error flag: a new error in the clearing cycle keeps the flag set.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			errFlag_r <= 1'b0;
			errOutN_r <= 1'b1;
		end else if (checksumErrEvent) begin
			errFlag_r <= 1'b1;
			errOutN_r <= 1'b0;
		end else if (readDone && ctrlRead_r) begin
			errFlag_r <= 1'b0;
			errOutN_r <= 1'b1;
		end
	end

	assign checksum_error_out_n = errOutN_r;

	// ----------------------------------------------------------------
	// Readback selection
	// ----------------------------------------------------------------
	logic [ARG_W-1:0] rbData; // Selected register contents.

	// Channel registers live outside this block and read as zero here.
	always_comb begin
		rbData = '0;
		if (rbType == RB_TYPE_SPECIAL) begin
			unique case (rbSel)
				RB_CTRL:  rbData = {11'h000, tempS_r[1], errFlag_r, ctrl_r};
				RB_GROUP_OFFSET_ZERO:  rbData = {2'h0, group_offset_zero_r};
				RB_GROUP_OFFSET_ONE:  rbData = {2'h0, group_offset_one_r};
				RB_BANK0: rbData = {8'h00, bankLo_r};
				RB_BANK1: rbData = {8'h00, bankHi_r};
				RB_GPIO:  rbData = {15'h0000, gpioOe ? gpioOut : gpioS_r[1]};
				default:  rbData = '0;
			endcase
		end
	end

	// The output drives from selection until the next frame has sent it.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rbState_r  <= RB_IDLE;
			readWord_r <= '0;
			ctrlRead_r <= 1'b0;
		end else begin
			unique case (rbState_r)
				RB_IDLE: begin
					if (isSpecial && holdWord_r.func == FN_READSEL && rbValid) begin
						rbState_r  <= RB_ARMED;
						readWord_r <= {8'h00, rbData};
						ctrlRead_r <= rbType == RB_TYPE_SPECIAL && rbSel == RB_CTRL;
					end
				end
				RB_ARMED: begin
					if (readDone) begin
						rbState_r  <= RB_IDLE;
						ctrlRead_r <= 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			serialDataOutOe <= 1'b0;
		end else begin
			serialDataOutOe <= (rbState_r == RB_ARMED) && !readDone;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_ctrl_write: assert property (@(posedge ref_clk) disable iff (!rstn)
		isSpecial && holdWord_r.func == FN_CTRL |=>
		{inputBankSecondary, thermalShutdownEn, softPowerDown} == $past(holdWord_r.arg[2:0]))
		else $error("control bits not loaded");
	a_ofs_write: assert property (@(posedge ref_clk) disable iff (!rstn)
		isSpecial && holdWord_r.func == FN_GROUP_OFFSET_ONE |=> groupOffsetOne == $past(holdWord_r.arg[13:0]))
		else $error("offset not loaded");
	a_bank_block: assert property (@(posedge ref_clk) disable iff (!rstn)
		isSpecial && holdWord_r.func == FN_BANKALL |=>
		channelUsesSecondary[15:8] == channelUsesSecondary[7:0])
		else $error("block bank write mismatch");
	a_mon_pin: assert property (@(posedge ref_clk) disable iff (!rstn)
		isSpecial && holdWord_r.func == FN_MONITOR && holdWord_r.arg[5:4] == 2'h3 |=>
		monitorPinSel && monitorEnable)
		else $error("monitor pin not selected");
	a_err_set: assert property (@(posedge ref_clk) disable iff (!rstn)
		checksumErrEvent |=> errFlag_r && !checksum_error_out_n)
		else $error("checksum error not flagged");
	a_err_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
		readDone && ctrlRead_r && !checksumErrEvent |=> checksum_error_out_n)
		else $error("error pin not released");
	a_reserved_word: assert property (@(posedge ref_clk) disable iff (!rstn)
		isSpecial && (holdWord_r.func == 6'h04 || holdWord_r.func == 6'h08) |=>
		$stable(ctrl_r) && $stable(channelUsesSecondary) && $stable(rbState_r))
		else $error("reserved code changed state");
	a_exec_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
		!$stable(mon_r) |-> $past(execNow))
		else $error("register changed without frame end");
	a_read_arm: assert property (@(posedge ref_clk) disable iff (!rstn)
		isSpecial && holdWord_r.func == FN_READSEL && rbValid && rbState_r == RB_IDLE |=>
		##1 serialDataOutOe)
		else $error("readback output not driven");

	c_read_ctrl: cover property (@(posedge ref_clk) disable iff (!rstn) readDone && ctrlRead_r);
	c_bank_all:  cover property (@(posedge ref_clk) disable iff (!rstn)
		isSpecial && holdWord_r.func == FN_BANKALL);
	c_err_race:  cover property (@(posedge ref_clk) disable iff (!rstn)
		checksumErrEvent && readDone && ctrlRead_r);
endmodule // dsf_decoder
`default_nettype wire

// ===== verilog/dsf_pkg.sv
// Shared constants and types for the special-function word decoder.
// Assumes a 24-bit serial word, MSB first, two mode bits on top.
package dsf_pkg;
	// ----------------------------------------------------------------
	// Serial word layout
	// ----------------------------------------------------------------
	localparam int WORD_W   = 24;      // Bits in one serial frame.
	localparam int FUNC_W   = 6;       // Function code width.
	localparam int ARG_W    = 16;      // Argument width.
	localparam int CNT_W    = 5;       // Bit counter width.
	localparam logic [CNT_W-1:0] LAST_BIT = 5'h17; // Index of the 24th bit.
	localparam logic [CNT_W-1:0] OVER_BIT = 5'h18; // A 25th bit spoils the frame.
	localparam logic [1:0] MODE_SPECIAL = 2'h0;    // Mode bits for special function.

	typedef struct packed {
		logic [1:0]        mode;      // Mode bits.
		logic [FUNC_W-1:0] func;      // Function code.
		logic [ARG_W-1:0]  arg;       // Argument bits.
	} dsf_word_t;

	// ----------------------------------------------------------------
	// Function codes
	// ----------------------------------------------------------------
	localparam logic [FUNC_W-1:0] FN_NOP      = 6'h00; // No operation.
	localparam logic [FUNC_W-1:0] FN_CTRL     = 6'h01; // Write control bits.
	localparam logic [FUNC_W-1:0] FN_GROUP_OFFSET_ZERO     = 6'h02; // Write first group offset.
	localparam logic [FUNC_W-1:0] FN_GROUP_OFFSET_ONE     = 6'h03; // Write second group offset.
	localparam logic [FUNC_W-1:0] FN_READSEL  = 6'h05; // Select readback.
	localparam logic [FUNC_W-1:0] FN_BANK0    = 6'h06; // Bank select, low channels.
	localparam logic [FUNC_W-1:0] FN_BANK1    = 6'h07; // Bank select, high channels.
	localparam logic [FUNC_W-1:0] FN_BANKALL  = 6'h0B; // Both bank select registers.
	localparam logic [FUNC_W-1:0] FN_MONITOR  = 6'h0C; // Monitor multiplexer.
	localparam logic [FUNC_W-1:0] FN_GPIO     = 6'h0D; // General-purpose pin setup.

	// ----------------------------------------------------------------
	// Field widths and positions
	// ----------------------------------------------------------------
	localparam int CTRL_W = 3;    // Writable control bits.
	localparam int OFS_W  = 14;   // Group offset width.
	localparam int BANK_W = 8;    // Bank select width.
	localparam int MON_W  = 6;    // Monitor setting width.
	localparam int MON_EN_BIT  = 5; // Monitor enable.
	localparam int MON_PIN_BIT = 4; // Pin rather than channel.
	localparam int GPIO_DIR_BIT = 1; // One makes the pin an output.
	localparam int GPIO_VAL_BIT = 0; // Driven value or read level.
	localparam int RB_TYPE_HI = 15; // Readback type field top.
	localparam int RB_TYPE_LO = 13; // Readback type field bottom.
	localparam int RB_SEL_HI  = 12; // Readback selection field top.
	localparam int RB_SEL_LO  = 7;  // Readback selection field bottom.
	localparam logic [2:0] RB_TYPE_SPECIAL = 3'h4; // Special register readback.
	localparam logic [2:0] RB_TYPE_LIMIT   = 3'h3; // Highest channel register type.
	localparam logic [5:0] RB_CH_FIRST = 6'h08;    // Channel 0 code.
	localparam logic [5:0] RB_CH_LAST  = 6'h17;    // Channel 15 code.
	localparam logic [5:0] RB_CTRL  = 6'h01; // Control readback.
	localparam logic [5:0] RB_GROUP_OFFSET_ZERO  = 6'h02; // First offset readback.
	localparam logic [5:0] RB_GROUP_OFFSET_ONE  = 6'h03; // Second offset readback.
	localparam logic [5:0] RB_BANK0 = 6'h06; // Low bank select readback.
	localparam logic [5:0] RB_BANK1 = 6'h07; // High bank select readback.
	localparam logic [5:0] RB_GPIO  = 6'h0B; // Pin level readback.

	// Readback handshake states.
	typedef enum logic [1:0] {
		RB_IDLE  = 2'b01,
		RB_ARMED = 2'b10
	} dsf_rb_state_t;
endpackage
